// ---- acquisition_engine.sv ----
`timescale 1ns/100ps
module acquisition_engine
    import acq_pkg::*;
#(
    parameter int PODS = PODS_PER_ENGINE,
    parameter int TAPS = DELAY_TAPS,
    parameter int SAMPLES = CAL_SAMPLES
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [PODS-1:0][DATA_PER_POD-1:0] podData,
    input wire logic [PODS-1:0] podClockData,
    input wire logic [STATE_CLOCKS-1:0] stateClock,
    input wire logic acqMode,
    input wire logic smallVariant,
    input wire logic configLoad,
    input wire logic [STATE_CLOCKS-1:0] clockAssign,
    input wire logic [PODS-1:0] podClockIsState,
    input wire logic [PODS-1:0] thresholdLoad,
    input wire logic [PODS-1:0][THRESHOLD_WIDTH-1:0] thresholdValue,
    input wire logic testMode,
    input wire logic testBit,
    input wire logic fastPhaseTick,
    input wire logic phaseSync,
    input wire logic fastRate,
    input wire logic clockMaster,
    input wire logic [RATIO_WIDTH-1:0] divideRatio,
    input wire logic slowClockIn,
    input wire logic runCmd,
    input wire logic stopCmd,
    input wire logic [ENGINE_CHANNELS-1:0] patternValue,
    input wire logic [ENGINE_CHANNELS-1:0] patternMask,
    input wire logic [COUNT_WIDTH-1:0] eventTarget,
    input wire logic [DATA_PER_POD-1:0] rangeLow,
    input wire logic [DATA_PER_POD-1:0] rangeHigh,
    input wire logic [ENGINE_CHANNELS-1:0] qualifyValue,
    input wire logic [ENGINE_CHANNELS-1:0] qualifyMask,
    output logic [PODS-1:0][THRESHOLD_WIDTH-1:0] thresholdLevel,
    output logic configError,
    output logic [STATE_CLOCKS-1:0] activeClocks,
    output logic slowClockOut,
    output logic [$clog2(PHASE_COUNT)-1:0] samplePhase,
    output logic calibrating,
    output logic [$clog2(TAPS)-1:0] chosenTap,
    output logic armed,
    output logic triggered,
    output logic [ENGINE_CHANNELS-1:0] storeData,
    output logic storeValid
);
    localparam int TW = $clog2(TAPS);
    localparam int PW = $clog2(PHASE_COUNT);

    // Masked compare shared by the trigger pattern and the qualifier
    function automatic logic matchFn(input logic [ENGINE_CHANNELS-1:0] value,
                                     input logic [ENGINE_CHANNELS-1:0] target,
                                     input logic [ENGINE_CHANNELS-1:0] mask);
        matchFn = ((value ^ target) & mask) == '0;
    endfunction

    // Ones count for the clock assignment check
    function automatic logic [2:0] countOnes(input logic [STATE_CLOCKS-1:0] bits);
        logic [2:0] total;
        total = '0;
        for (int i = 0; i < STATE_CLOCKS; i++)
            total = total + 3'(bits[i]);
        countOnes = total;
    endfunction

    // ------------------------------------------------------------
    // Configuration and thresholds
    // ------------------------------------------------------------
    logic [STATE_CLOCKS-1:0] clocks; // Accepted clock assignment
    logic reject; // Last load refused
    logic [PODS-1:0][THRESHOLD_WIDTH-1:0] levels; // Per-pod thresholds
    logic [STATE_CLOCKS-1:0] next_clocks;
    logic next_reject;
    logic [PODS-1:0][THRESHOLD_WIDTH-1:0] next_levels;
    logic [2:0] clockLimit; // Variant ceiling

    // A refused load keeps the previous legal assignment
    always_comb
    begin
        next_clocks = clocks;
        next_reject = reject;
        next_levels = levels;
        clockLimit = smallVariant ? MAX_CLOCKS_SMALL : MAX_CLOCKS_LARGE;
        if (configLoad)
        begin
            if (countOnes(clockAssign) > clockLimit)
            begin
                next_reject = 1'b1;
            end
            else
            begin
                next_reject = 1'b0;
                next_clocks = clockAssign;
            end
        end
        for (int p = 0; p < PODS; p++)
        begin
            if (thresholdLoad[p])
                next_levels[p] = thresholdValue[p];
        end
    end

    // Register only
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            clocks <= '0;
            reject <= 1'b0;
            levels <= '0;
        end
        else
        begin
            clocks <= next_clocks;
            reject <= next_reject;
            levels <= next_levels;
        end
    end

    // One level per pod covers its clock and data alike
    assign thresholdLevel = levels;
    assign configError = reject;
    assign activeClocks = clocks;

    // ------------------------------------------------------------
    // Channel assembly and test injection
    // ------------------------------------------------------------
    logic [ENGINE_CHANNELS-1:0] channels; // Comparator outputs
    logic [PODS-1:0][2*COMPARATOR_WIDTH-1:0] compOut; // Two comparators per pod

    // In test the serial bit replaces every comparator output
    always_comb
    begin
        for (int p = 0; p < PODS; p++)
        begin
            if (testMode)
                compOut[p] = {(2*COMPARATOR_WIDTH){testBit}};
            else
                compOut[p] = {1'b0, podClockData[p], podData[p]};
            // Clock/data sits above the sixteen data bits
            channels[p*CHANNELS_PER_POD +: CHANNELS_PER_POD] = compOut[p][CHANNELS_PER_POD-1:0];
            if (acqMode == MODE_STATE && podClockIsState[p] && !testMode)
                channels[p*CHANNELS_PER_POD + CLOCK_POS] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Delay taps for skew placement
    // ------------------------------------------------------------
    logic [TAPS:0][ENGINE_CHANNELS-1:0] taps; // taps[0] is the live input
    logic [TAPS:1][ENGINE_CHANNELS-1:0] tapRegs, next_taps;
    logic [TAPS-1:0] tapUnstable; // Data moving at this tap
    logic [TW-1:0] tapSel; // Tap used for capture

    // Plain shift line; each stage adds one clock of delay
    always_comb
    begin
        for (int t = 1; t <= TAPS; t++)
            next_taps[t] = taps[t-1];
        for (int t = 0; t < TAPS; t++)
            tapUnstable[t] = taps[t] != taps[t+1];
    end

    // Register only
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            tapRegs <= '0;
        else
            tapRegs <= next_taps;
    end

    assign taps = {tapRegs, channels};

    // ------------------------------------------------------------
    // Sample clock generation
    // ------------------------------------------------------------
    logic [STATE_CLOCKS-1:0] stateClockLast; // For edge detection
    logic [PW-1:0] phase; // Four-phase position
    logic [STATE_CLOCKS-1:0] next_stateClockLast;
    logic [PW-1:0] next_phase;
    logic slowTick; // Own divided tick
    logic stateTick; // Any assigned clock rose
    logic sampleTick; // Capture strobe for this engine

    // Phase count is cleared by sync so every engine agrees
    always_comb
    begin
        next_stateClockLast = stateClock;
        next_phase = phase;
        if (phaseSync)
            next_phase = '0;
        else if (fastPhaseTick)
            next_phase = phase + PW'(1);
        stateTick = |(stateClock & ~stateClockLast & clocks);
        if (acqMode == MODE_STATE)
            sampleTick = stateTick;
        else if (fastRate)
            sampleTick = fastPhaseTick;
        else
            sampleTick = clockMaster ? slowTick : slowClockIn;
    end

    // Register only
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            stateClockLast <= '0;
            phase <= '0;
        end
        else
        begin
            stateClockLast <= next_stateClockLast;
            phase <= next_phase;
        end
    end

    sample_divider #(
        .RATIO_BITS(RATIO_WIDTH)
    ) divider (
        .clock(clock),
        .rst_b(rst_b),
        .loadRatio(configLoad),
        .ratio(divideRatio),
        .fastTick(fastPhaseTick),
        .slowTick(slowTick)
    );

    // Only the master drives a live divided clock to its peers
    assign slowClockOut = clockMaster & slowTick;
    assign samplePhase = phase;

    // ------------------------------------------------------------
    // Run control, trigger and storage
    // ------------------------------------------------------------
    engine_state_type state; // Run sequence
    logic [COUNT_WIDTH-1:0] events; // Pattern occurrences
    logic [ENGINE_CHANNELS-1:0] stored; // Last stored sample
    logic valid; // Store strobe
    logic calStart; // Kick off optimisation
    logic [TW-1:0] tapHeld; // Tap fixed after calibration
    engine_state_type next_state;
    logic [COUNT_WIDTH-1:0] next_events;
    logic [ENGINE_CHANNELS-1:0] next_stored;
    logic next_valid;
    logic next_calStart;
    logic [TW-1:0] next_tapHeld;
    logic calDone; // Sweep finished
    logic [TW-1:0] calTap; // Sweep result
    logic [ENGINE_CHANNELS-1:0] sample; // Data at chosen tap
    logic [DATA_PER_POD-1:0] rangeWord; // First pod data for range

    skew_calibrator #(
        .TAPS(TAPS),
        .SAMPLES(SAMPLES)
    ) calibrator (
        .clock(clock),
        .rst_b(rst_b),
        .start(calStart),
        .sampleTick(sampleTick),
        .tapUnstable(tapUnstable),
        .done(calDone),
        .bestTap(calTap)
    );

    // Nothing is stored until the sweep has settled a tap
    always_comb
    begin
        next_state = state;
        next_events = events;
        next_stored = stored;
        next_valid = 1'b0;
        next_calStart = 1'b0;
        next_tapHeld = tapHeld;
        tapSel = tapHeld;
        sample = taps[{1'b0, tapSel} + (TW+1)'(1)];
        rangeWord = sample[DATA_PER_POD-1:0];
        case (state)
            ST_IDLE:
            begin
                if (runCmd)
                begin
                    next_state = ST_CALIBRATE;
                    next_calStart = 1'b1;
                    next_events = '0;
                end
            end
            ST_CALIBRATE:
            begin
                if (calDone && !calStart)
                begin
                    next_tapHeld = calTap;
                    next_state = ST_ARMED;
                end
            end
            ST_ARMED, ST_TRIGGERED:
            begin
                if (sampleTick)
                begin
                    // Test data is kept whole so both pipelines are seen
                    if (testMode || matchFn(sample, qualifyValue, qualifyMask))
                    begin
                        next_stored = sample;
                        next_valid = 1'b1;
                    end
                    if (state == ST_ARMED)
                    begin
                        if (events >= eventTarget)
                        begin
                            if (rangeWord >= rangeLow && rangeWord <= rangeHigh)
                                next_state = ST_TRIGGERED;
                        end
                        else if (matchFn(sample, patternValue, patternMask))
                        begin
                            next_events = events + COUNT_WIDTH'(1);
                        end
                    end
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
        if (stopCmd)
            next_state = ST_IDLE;
    end

    // Register only
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            state <= ST_IDLE;
            events <= '0;
            stored <= '0;
            valid <= 1'b0;
            calStart <= 1'b0;
            tapHeld <= '0;
        end
        else
        begin
            state <= next_state;
            events <= next_events;
            stored <= next_stored;
            valid <= next_valid;
            calStart <= next_calStart;
            tapHeld <= next_tapHeld;
        end
    end

    assign calibrating = (state == ST_CALIBRATE);
    assign chosenTap = tapHeld;
    assign armed = (state == ST_ARMED);
    assign triggered = (state == ST_TRIGGERED);
    assign storeData = stored;
    assign storeValid = valid;
endmodule

// ---- acq_pkg.sv ----
package acq_pkg;
    // ------------------------------------------------------------
    // Channel geometry
    // ------------------------------------------------------------
    localparam int DATA_PER_POD = 16;
    localparam int CHANNELS_PER_POD = 17;
    localparam int PODS_PER_ENGINE = 2;
    localparam int ENGINE_CHANNELS = 34;
    localparam int COMPARATOR_WIDTH = 9;
    localparam int STATE_CLOCKS = 4;
    localparam int CLOCK_POS = 16;
    // ------------------------------------------------------------
    // Clock assignment limits
    // ------------------------------------------------------------
    localparam logic [2:0] MAX_CLOCKS_LARGE = 3'h4;
    localparam logic [2:0] MAX_CLOCKS_SMALL = 3'h2;
    // ------------------------------------------------------------
    // Timing clock and calibration
    // ------------------------------------------------------------
    localparam int FAST_CLOCK_MHZ = 125;
    localparam int PHASE_COUNT = 4;
    localparam int DELAY_TAPS = 4;
    localparam int CAL_SAMPLES = 16;
    localparam int THRESHOLD_WIDTH = 8;
    localparam int COUNT_WIDTH = 16;
    localparam int RATIO_WIDTH = 16;
    localparam logic [15:0] RATIO_RESET = 16'h0002;
    // ------------------------------------------------------------
    // Engine states and acquisition modes
    // ------------------------------------------------------------
    typedef enum logic {MODE_STATE, MODE_TIMING} acq_mode_type;
    typedef enum {ST_IDLE, ST_CALIBRATE, ST_ARMED, ST_TRIGGERED} engine_state_type;
    typedef enum {CAL_IDLE, CAL_MEASURE, CAL_DONE} cal_state_type;
endpackage

// ---- sample_divider.sv ----
`timescale 1ns/100ps
module sample_divider
    import acq_pkg::*;
#(
    parameter int RATIO_BITS = RATIO_WIDTH
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic loadRatio,
    input wire logic [RATIO_BITS-1:0] ratio,
    input wire logic fastTick,
    output logic slowTick
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [RATIO_BITS-1:0] heldRatio; // Ratio frozen for one run
    logic [RATIO_BITS-1:0] count; // Fast edges seen this period
    logic tick; // Registered output pulse
    logic [RATIO_BITS-1:0] next_heldRatio;
    logic [RATIO_BITS-1:0] next_count;
    logic next_tick;

    // Ratio only changes on load, so a run sees one steady rate
    always_comb
    begin
        next_heldRatio = heldRatio;
        next_count = count;
        next_tick = 1'b0;
        if (loadRatio)
        begin
            // Zero would stall the sampler; treat it as one
            next_heldRatio = (ratio == '0) ? RATIO_BITS'(1) : ratio;
            next_count = '0;
        end
        else if (fastTick)
        begin
            if (count + RATIO_BITS'(1) >= heldRatio)
            begin
                next_count = '0;
                next_tick = 1'b1;
            end
            else
            begin
                next_count = count + RATIO_BITS'(1);
            end
        end
    end

    // Register only
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            heldRatio <= RATIO_BITS'(RATIO_RESET);
            count <= '0;
            tick <= 1'b0;
        end
        else
        begin
            heldRatio <= next_heldRatio;
            count <= next_count;
            tick <= next_tick;
        end
    end

    assign slowTick = tick;
endmodule

// ---- skew_calibrator.sv ----
`timescale 1ns/100ps
module skew_calibrator
    import acq_pkg::*;
#(
    parameter int TAPS = DELAY_TAPS,
    parameter int SAMPLES = CAL_SAMPLES
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic start,
    input wire logic sampleTick,
    input wire logic [TAPS-1:0] tapUnstable,
    output logic done,
    output logic [$clog2(TAPS)-1:0] bestTap
);
    localparam int TW = $clog2(TAPS);
    localparam int SW = $clog2(SAMPLES + 1);
    // ------------------------------------------------------------
    // Sweep state
    // ------------------------------------------------------------
    cal_state_type state; // Sweep phase
    logic [TW-1:0] tap; // Tap under test
    logic [SW-1:0] samples; // Ticks seen on this tap
    logic [SW-1:0] errors; // Unstable hits on this tap
    logic [SW-1:0] bestErrors; // Fewest hits so far
    logic [TW-1:0] best; // Tap with fewest hits
    cal_state_type next_state;
    logic [TW-1:0] next_tap;
    logic [SW-1:0] next_samples;
    logic [SW-1:0] next_errors;
    logic [SW-1:0] next_bestErrors;
    logic [TW-1:0] next_best;
    logic [SW-1:0] errorsNow; // Count including this tick

    // Each tap is scored by how often data moves at the capture edge
    always_comb
    begin
        next_state = state;
        next_tap = tap;
        next_samples = samples;
        next_errors = errors;
        next_bestErrors = bestErrors;
        next_best = best;
        errorsNow = errors + SW'(tapUnstable[tap]);
        case (state)
            CAL_IDLE, CAL_DONE:
            begin
                if (start)
                begin
                    next_state = CAL_MEASURE;
                    next_tap = '0;
                    next_samples = '0;
                    next_errors = '0;
                    next_bestErrors = '1;
                    next_best = '0;
                end
            end
            CAL_MEASURE:
            begin
                if (sampleTick)
                begin
                    next_samples = samples + SW'(1);
                    next_errors = errorsNow;
                    if (samples + SW'(1) == SW'(SAMPLES))
                    begin
                        // Strict compare keeps the earliest tap on a tie
                        if (errorsNow < bestErrors)
                        begin
                            next_bestErrors = errorsNow;
                            next_best = tap;
                        end
                        next_samples = '0;
                        next_errors = '0;
                        if (tap == TW'(TAPS - 1))
                            next_state = CAL_DONE;
                        else
                            next_tap = tap + TW'(1);
                    end
                end
            end
            default:
            begin
                next_state = CAL_IDLE;
            end
        endcase
    end

    // Register only
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            state <= CAL_IDLE;
            tap <= '0;
            samples <= '0;
            errors <= '0;
            bestErrors <= '1;
            best <= '0;
        end
        else
        begin
            state <= next_state;
            tap <= next_tap;
            samples <= next_samples;
            errors <= next_errors;
            bestErrors <= next_bestErrors;
            best <= next_best;
        end
    end

    assign done = (state == CAL_DONE);
    assign bestTap = best;
endmodule

// ---- acq_engine_properties.sv ----
`timescale 1ns/100ps
module acq_engine_properties
    import acq_pkg::*;
#(
    parameter int PODS = PODS_PER_ENGINE
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic configLoad,
    input wire logic smallVariant,
    input wire logic [STATE_CLOCKS-1:0] clockAssign,
    input wire logic [PODS-1:0] thresholdLoad,
    input wire logic [PODS-1:0][THRESHOLD_WIDTH-1:0] thresholdValue,
    input wire logic fastPhaseTick,
    input wire logic phaseSync,
    input wire logic runCmd,
    input wire logic stopCmd,
    input wire logic [PODS-1:0][THRESHOLD_WIDTH-1:0] thresholdLevel,
    input wire logic configError,
    input wire logic [STATE_CLOCKS-1:0] activeClocks,
    input wire logic [$clog2(PHASE_COUNT)-1:0] samplePhase,
    input wire logic calibrating,
    input wire logic armed,
    input wire logic triggered,
    input wire logic storeValid
);
    // ----------------------------------------
    // Single domain, sync reset masks checks
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    // Refused set must leave the old one in place
    a_small_refuse:
    assert property (configLoad && smallVariant && $countones(clockAssign) > 2 |=> configError && $stable(activeClocks))
        else $error("clock set not refused");
    a_large_accept:
    assert property (configLoad && !smallVariant |=> !configError && activeClocks == $past(clockAssign))
        else $error("clock set not taken");
    a_threshold_load:
    assert property (thresholdLoad[0] |=> thresholdLevel[0] == $past(thresholdValue[0])) else $error("threshold lost");
    a_threshold_hold:
    assert property (!thresholdLoad[1] |=> $stable(thresholdLevel[1])) else $error("threshold moved");
    a_sync_clear:
    assert property (phaseSync |=> samplePhase == '0) else $error("phase not cleared");
    a_phase_step:
    assert property (fastPhaseTick && !phaseSync |=> samplePhase == 2'($past(samplePhase) + 1)) else $error("phase step");
    a_run_calibrate:
    assert property (runCmd && !stopCmd && !(calibrating || armed || triggered) |=> calibrating) else $error("no calibration");
    // Nothing may reach storage while delays are still being tuned
    a_store_after_cal:
    assert property (storeValid |-> !$past(calibrating)) else $error("stored while calibrating");
    cover property (configLoad && smallVariant ##1 configError);
    cover property ($rose(armed));
    cover property (storeValid);
endmodule
bind acquisition_engine acq_engine_properties #(.PODS(PODS)) i_properties (.*);

// ---- sut_model.sv ----
`timescale 1ns/100ps
module sut_model
    import acq_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    output logic [PODS_PER_ENGINE-1:0][DATA_PER_POD-1:0] podData,
    output logic [PODS_PER_ENGINE-1:0] podClockData,
    output logic [STATE_CLOCKS-1:0] stateClock
);
    // Cycle count of the target, sets the clock period
    int cycles = 0;
    initial
    begin
        {podData, podClockData, stateClock} = '0;
    end
    // Fresh data every cycle, so a stale capture never matches by luck
    always @(posedge clock)
    begin
        cycles <= rst_b ? cycles + 1 : 0;
        podData <= $urandom;
        podClockData <= 2'($urandom);
        stateClock <= {4{cycles[2]}};
    end
endmodule

// ---- testbench.sv ----
`timescale 1ns/100ps
module testbench;
    import acq_pkg::*;
    // Engine ports: inputs from the bench and the target model, and the outputs observed
    logic clock, rst_b, acqMode, smallVariant, configLoad, testMode, testBit, fastPhaseTick;
    logic phaseSync, fastRate, clockMaster, slowClockIn, runCmd, stopCmd;
    logic [3:0] clockAssign, stateClock, activeClocks;
    logic [1:0] podClockIsState, thresholdLoad, podClockData, samplePhase, chosenTap;
    logic [1:0][7:0] thresholdValue, thresholdLevel;
    logic [1:0][15:0] podData;
    logic [15:0] divideRatio, eventTarget, rangeLow, rangeHigh;
    logic [33:0] patternValue, patternMask, qualifyValue, qualifyMask, storeData;
    logic configError, slowClockOut, calibrating, armed, triggered, storeValid;
    // Reference model state
    int error_cnt, tests_run, act, n, ph, k, b;
    int thr[2];
    logic [33:0] hist[4];
    acquisition_engine #(.SAMPLES(2)) i_dut (.*);
    sut_model i_sut (.*);
    task automatic check_vec(input logic [33:0] got, input logic [33:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, input logic exp);
        check_vec(34'(got), 34'(exp));
    endtask
    task automatic final_report;
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // Whole run is a few hundred cycles
    initial
    begin
        #(100 * 5000);
        error_cnt++;
        final_report;
    end
    initial
    begin
        void'($urandom(54));
        {rst_b, acqMode, smallVariant, configLoad, testMode, testBit, fastPhaseTick, phaseSync} = '0;
        {fastRate, clockMaster, slowClockIn, runCmd, stopCmd, clockAssign, podClockIsState} = '0;
        {thresholdLoad, thresholdValue, qualifyValue, qualifyMask} = '0;
        {patternValue, patternMask, rangeLow, rangeHigh} = 100'({$urandom, $urandom, $urandom, $urandom});
        divideRatio = 16'h0002;
        {eventTarget, rangeLow, rangeHigh} = {16'h0000, 32'hFFFFFFFF};
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        // Every clock set on both variants
        for (k = 0; k < 32; k++)
        begin
            @(posedge clock);
            configLoad <= 1'b1;
            smallVariant <= k[4];
            clockAssign <= k[3:0];
            n = $countones(k[3:0]) > (k[4] ? 2 : 4);
            act = n ? act : k[3:0];
            @(posedge clock);
            configLoad <= 1'b0;
            #1;
            check_flag(configError, n[0]);
            check_vec(34'(activeClocks), 34'(act));
        end
        // Per-pod thresholds, the other pod untouched
        for (k = 0; k < 4; k++)
        begin
            @(posedge clock);
            thr[k % 2] = $urandom % 256;
            thresholdValue[k % 2] <= 8'(thr[k % 2]);
            thresholdLoad <= 2'(1 << (k % 2));
            @(posedge clock);
            thresholdLoad <= '0;
            #1;
            check_vec(34'(thresholdLevel), 34'({8'(thr[1]), 8'(thr[0])}));
        end
        // Sync and tick together: sync must win
        @(posedge clock);
        phaseSync <= 1'b1;
        fastPhaseTick <= 1'b1;
        ph = 0;
        for (k = 0; k < 20; k++)
        begin
            @(posedge clock);
            n = $urandom % 4;
            fastPhaseTick <= n[0];
            slowClockIn <= n[1];
            phaseSync <= 1'b0;
            #1;
            check_vec(34'(samplePhase), 34'(ph % 4));
            ph += n % 2;
        end
        // Divide by three over thirty ticks
        @(posedge clock);
        {divideRatio, configLoad, clockMaster, fastPhaseTick} <= {16'h0003, 3'b110};
        clockAssign <= '0;
        act = 0;
        @(posedge clock);
        configLoad <= 1'b0;
        fastPhaseTick <= 1'b1;
        n = 0;
        for (k = 0; k < 36; k++)
        begin
            @(posedge clock);
            if (k == 29)
                fastPhaseTick <= 1'b0;
            #1;
            n += slowClockOut;
        end
        check_vec(34'(n), 34'(10));
        // Timing run with injected test bits, pod clocks flagged as clocks
        @(posedge clock);
        {acqMode, fastRate, testMode, testBit, runCmd, fastPhaseTick} <= '1;
        podClockIsState <= 2'b11;
        @(posedge clock);
        runCmd <= 1'b0;
        #1;
        check_flag(calibrating, 1'b1);
        k = 0;
        while (armed !== 1'b1 && k < 500)
        begin
            @(posedge clock);
            #1;
            k++;
        end
        check_flag(armed, 1'b1);
        check_vec(34'(chosenTap), 34'(0));
        for (b = 0; b < 3; b++)
        begin
            @(posedge clock);
            testBit <= ~b[0];
            repeat (6) @(posedge clock);
            #1;
            check_flag(storeValid, 1'b1);
            check_vec(storeData, {34{~b[0]}});
        end
        check_flag(triggered, 1'b1);
        // Timing mode keeps pod clock bits
        @(posedge clock);
        testMode <= 1'b0;
        for (k = 0; k < 12; k++)
        begin
            @(posedge clock);
            #1;
            if (k > 1)
                check_vec(storeData, hist[(k - 2) % 4]);
            hist[k % 4] = {podClockData[1], podData[1], podClockData[0], podData[0]};
        end
        // State mode zeroes clocks used as clocks
        @(posedge clock);
        {acqMode, configLoad, clockAssign} <= 6'b010001;
        n = 0;
        for (k = 0; k < 24; k++)
        begin
            @(posedge clock);
            configLoad <= 1'b0;
            #1;
            n += storeValid;
            if (storeValid === 1'b1)
                check_flag(storeData[33] | storeData[16], 1'b0);
        end
        check_flag(n >= 2, 1'b1);
        @(posedge clock);
        stopCmd <= 1'b1;
        @(posedge clock);
        stopCmd <= 1'b0;
        #1;
        check_vec(34'({armed, triggered, calibrating}), 34'(0));
        final_report;
    end
endmodule
